// ### verilog/exec_subset_pkg.sv
// Package with opcodes, field layouts and types for the instruction subset executor
// What this block does
// RULE1: Decrement-skip routes result by destination bit
// RULE2: Zero decrement result skips next, two cycles
// RULE3: Decrement-skip leaves status flags unchanged
// RULE4: Increment-skip routes result, skips on zero
// RULE5: Increment-skip leaves status flags unchanged
// RULE6: Branch loads eleven-bit immediate, two cycles
// RULE7: Branch takes counter bits 12:11 from latch
// RULE8: OR immediate into accumulator, update zero
// RULE9: Plain increment routes result, updates zero
// RULE10: OR register routes result, updates zero
// RULE11: Zero flag set only on all-zero result
package exec_subset_pkg;

  // Fourteen-bit instruction word fields
  localparam int unsigned INSN_W       = 14;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned PC_W         = 13;
  localparam int unsigned FADDR_W      = 7;
  localparam int unsigned DEST_BIT     = 7;
  localparam int unsigned BRANCH_K_W   = 11;
  localparam int unsigned LATCH_HI_BIT = 4;
  localparam int unsigned LATCH_LO_BIT = 3;

  // Opcode prefixes for byte-oriented forms (bits 13:8)
  localparam logic [5:0] OP_DEC_SKIP  = 6'h0b;
  localparam logic [5:0] OP_INC_SKIP  = 6'h0f;
  localparam logic [5:0] OP_INC       = 6'h0a;
  localparam logic [5:0] OP_OR_REG    = 6'h04;
  localparam logic [5:0] OP_OR_IMM    = 6'h38;
  // Branch prefix (bits 13:11)
  localparam logic [2:0] OP_BRANCH    = 3'h5;

  // Reset values and increment constants
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
  localparam logic [DATA_W-1:0] ONE_BYTE  = 8'h01;
  localparam logic [PC_W-1:0]   ONE_PC    = 13'h0001;

  // Executor phase
  typedef enum logic [1:0]
  {
    PH_RUN   = 2'b00,
    PH_FLUSH = 2'b01
  } exec_phase_t;

  // Instruction being issued
  typedef struct packed
  {
    logic              valid;
    logic [INSN_W-1:0] word;
  } insn_t;

  // Write-back toward the register file
  typedef struct packed
  {
    logic               wr;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } file_wr_t;

endpackage

// ### verilog/exec_alu.sv
// Combinational ALU for the instruction subset
`timescale 1ns/1ns
module exec_alu
  import exec_subset_pkg::*;
(
  // Operands
  input  wire logic [INSN_W-1:0] word_in,
  input  wire logic [DATA_W-1:0] acc_in,
  input  wire logic [DATA_W-1:0] file_in,
  // Results
  output logic [DATA_W-1:0]      result_out,
  output logic                   is_dec_skip_out,
  output logic                   is_inc_skip_out,
  output logic                   is_inc_out,
  output logic                   is_or_reg_out,
  output logic                   is_or_imm_out,
  output logic                   is_branch_out
);

  // Decode and compute in one pass
  always_comb
  begin
    is_dec_skip_out = (word_in[13:8] == OP_DEC_SKIP);
    is_inc_skip_out = (word_in[13:8] == OP_INC_SKIP);
    is_inc_out      = (word_in[13:8] == OP_INC);
    is_or_reg_out   = (word_in[13:8] == OP_OR_REG);
    is_or_imm_out   = (word_in[13:8] == OP_OR_IMM);
    is_branch_out   = (word_in[13:11] == OP_BRANCH);
    if (is_dec_skip_out)
    begin
      result_out = file_in - ONE_BYTE;
    end
    else if (is_inc_skip_out || is_inc_out)
    begin
      result_out = file_in + ONE_BYTE;
    end
    else if (is_or_reg_out)
    begin
      result_out = acc_in | file_in;
    end
    else if (is_or_imm_out)
    begin
      result_out = acc_in | word_in[DATA_W-1:0];
    end
    else
    begin
      result_out = acc_in;
    end
  end

endmodule

// ### verilog/core_instruction_subset_exec.sv
// Executor for the increment, decrement, OR and branch instruction subset
`timescale 1ns/1ns
module core_instruction_subset_exec
  import exec_subset_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_sys_in,
  input  wire logic                          resetn_in,
  // Instruction issue, one per instruction cycle
  input  wire exec_subset_pkg::insn_t        insn_in,
  // Register file read data for the addressed register
  input  wire logic [exec_subset_pkg::DATA_W-1:0] file_data_in,
  // High counter latch contents
  input  wire logic [exec_subset_pkg::DATA_W-1:0] high_counter_latch_in,
  // Results
  output exec_subset_pkg::file_wr_t          file_wr_out,
  output logic [exec_subset_pkg::DATA_W-1:0] acc_out,
  output logic                               zero_flag_out,
  output logic [exec_subset_pkg::PC_W-1:0]   pc_out,
  output logic                               flush_out
);
  import exec_subset_pkg::*;

  // Registered state
  exec_phase_t       phase;            // Run or discard phase
  logic [DATA_W-1:0] acc;              // Accumulator
  logic              zero_flag;        // Zero status flag
  logic [PC_W-1:0]   pc;               // Program counter
  file_wr_t          file_wr;          // Register write-back
  logic              flush;            // Registered copy of the discard phase for the output
  // Next values
  exec_phase_t       next_phase;
  logic [DATA_W-1:0] next_acc;
  logic              next_zero_flag;
  logic [PC_W-1:0]   next_pc;
  file_wr_t          next_file_wr;
  logic              next_flush;
  // Decode outputs
  logic [DATA_W-1:0] result;
  logic              is_dec_skip;
  logic              is_inc_skip;
  logic              is_inc;
  logic              is_or_reg;
  logic              is_or_imm;
  logic              is_branch;
  logic              to_file;          // Destination bit set
  logic              res_zero;         // Result all zeros
  logic              executing;        // Valid and not discarded

  // Decode and arithmetic
  exec_alu u_alu
  (
    .word_in         (insn_in.word),
    .acc_in          (acc),
    .file_in         (file_data_in),
    .result_out      (result),
    .is_dec_skip_out (is_dec_skip),
    .is_inc_skip_out (is_inc_skip),
    .is_inc_out      (is_inc),
    .is_or_reg_out   (is_or_reg),
    .is_or_imm_out   (is_or_imm),
    .is_branch_out   (is_branch)
  );

  // Helper decodes
  always_comb
  begin
    to_file   = insn_in.word[DEST_BIT];
    res_zero  = (result == 8'h00);
    executing = insn_in.valid && (phase == PH_RUN);
  end

  // Next-state computation
  always_comb
  begin
    next_phase     = phase;
    next_acc       = acc;
    next_zero_flag = zero_flag;
    next_pc        = pc;
    next_file_wr   = '0;
    case (phase)
      PH_RUN:
      begin
        if (insn_in.valid)
        begin
          next_pc = pc + ONE_PC;
          if (is_dec_skip || is_inc_skip || is_inc || is_or_reg)
          begin
            // Route result by destination bit
            if (to_file)                                          // RULE1 RULE4 RULE9 RULE10
            begin
              next_file_wr.wr   = 1'b1;
              next_file_wr.addr = insn_in.word[FADDR_W-1:0];
              next_file_wr.data = result;
            end
            else
            begin
              next_acc = result;
            end
          end
          if (is_or_imm)
          begin
            next_acc = result;                                    // RULE8
          end
          // Zero flag only for the flag-affecting forms; skip forms leave it
          if (is_inc || is_or_reg || is_or_imm)                   // RULE3 RULE5
          begin
            next_zero_flag = res_zero;                            // RULE11
          end
          // Zero result of a skip form discards the next instruction
          if ((is_dec_skip || is_inc_skip) && res_zero)           // RULE2 RULE4
          begin
            next_phase = PH_FLUSH;
          end
          // Branch: immediate into low bits, latch bits into top bits
          if (is_branch)
          begin
            next_pc = {high_counter_latch_in[LATCH_HI_BIT:LATCH_LO_BIT],  // RULE7
                       insn_in.word[BRANCH_K_W-1:0]};                     // RULE6
            next_phase = PH_FLUSH;                                        // RULE6
          end
        end
      end
      PH_FLUSH:
      begin
        // Discarded slot executes as a no-operation
        if (insn_in.valid)
        begin
          next_pc    = pc + ONE_PC;
          next_phase = PH_RUN;
        end
      end
      default:
      begin
        next_phase = PH_RUN;
      end
    endcase
    // Discard indication follows the next phase so the output needs no decode
    next_flush = (next_phase == PH_FLUSH);                        // RULE2 RULE4 RULE6
  end

  // State registers
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      phase     <= PH_RUN;
      acc       <= ACC_RESET;
      zero_flag <= 1'b0;
      pc        <= PC_RESET;
      file_wr   <= '0;
      flush     <= 1'b0;
    end
    else
    begin
      phase     <= next_phase;
      acc       <= next_acc;
      zero_flag <= next_zero_flag;
      pc        <= next_pc;
      file_wr   <= next_file_wr;
      flush     <= next_flush;
    end
  end

  // Outputs straight from flip-flops
  always_comb
  begin
    file_wr_out   = file_wr;
    acc_out       = acc;
    zero_flag_out = zero_flag;
    pc_out        = pc;
    flush_out     = flush;
  end

  // Assertions
  property p_dec_route;                                                   // RULE1
    @(posedge clk_sys_in) disable iff (!resetn_in)
    executing && is_dec_skip && !to_file |=> acc == $past(file_data_in) - 8'h01 && !file_wr.wr;
  endproperty
  a_dec_route: assert property (p_dec_route) else $error("decrement result misrouted"); // RULE1

  property p_skip_flush;                                                  // RULE2
    @(posedge clk_sys_in) disable iff (!resetn_in)
    executing && (is_dec_skip || is_inc_skip) |=> (phase == PH_FLUSH) == $past(res_zero);
  endproperty
  a_skip_flush: assert property (p_skip_flush) else $error("skip flush wrong"); // RULE2

  property p_dec_flags;                                                   // RULE3
    @(posedge clk_sys_in) disable iff (!resetn_in)
    executing && is_dec_skip |=> $stable(zero_flag);
  endproperty
  a_dec_flags: assert property (p_dec_flags) else $error("decrement changed flag"); // RULE3

  property p_inc_skip_write;                                              // RULE4
    @(posedge clk_sys_in) disable iff (!resetn_in)
    executing && is_inc_skip && to_file |=> file_wr.wr && file_wr.data == $past(file_data_in) + 8'h01;
  endproperty
  a_inc_skip_write: assert property (p_inc_skip_write) else $error("increment-skip write wrong"); // RULE4

  property p_inc_skip_flags;                                              // RULE5
    @(posedge clk_sys_in) disable iff (!resetn_in)
    executing && is_inc_skip |=> $stable(zero_flag);
  endproperty
  a_inc_skip_flags: assert property (p_inc_skip_flags) else $error("increment-skip changed flag"); // RULE5

  property p_branch_pc;                                                   // RULE6
    @(posedge clk_sys_in) disable iff (!resetn_in)
    executing && is_branch |=> pc[10:0] == $past(insn_in.word[10:0]) && phase == PH_FLUSH;
  endproperty
  a_branch_pc: assert property (p_branch_pc) else $error("branch target wrong"); // RULE6

  property p_branch_hi;                                                   // RULE7
    @(posedge clk_sys_in) disable iff (!resetn_in)
    executing && is_branch |=> pc[12:11] == $past(high_counter_latch_in[4:3]);
  endproperty
  a_branch_hi: assert property (p_branch_hi) else $error("branch upper bits wrong"); // RULE7

  property p_or_imm;                                                      // RULE8
    @(posedge clk_sys_in) disable iff (!resetn_in)
    executing && is_or_imm |=> acc == ($past(acc) | $past(insn_in.word[7:0]));
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("OR immediate wrong"); // RULE8

  property p_zero_flag;                                                   // RULE11
    @(posedge clk_sys_in) disable iff (!resetn_in)
    executing && (is_inc || is_or_reg || is_or_imm) |=> zero_flag == ($past(result) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // RULE9 RULE10 RULE11

  // Main scenarios
  c_dec_skip: cover property (@(posedge clk_sys_in) executing && is_dec_skip && res_zero);
  c_branch:   cover property (@(posedge clk_sys_in) executing && is_branch);
  c_or_reg:   cover property (@(posedge clk_sys_in) executing && is_or_reg && to_file);

endmodule

// ### verif/core_instruction_subset_exec_bench.sv
// Self-checking bench for the instruction subset executor
`timescale 1ns/1ns
module core_instruction_subset_exec_bench;
  import exec_subset_pkg::*;
  // Design inputs and outputs
  logic              clk_sys_in;
  logic              resetn_in;
  insn_t             insn_in;
  logic [DATA_W-1:0] file_data_in;
  logic [DATA_W-1:0] high_counter_latch_in;
  file_wr_t          file_wr_out;
  logic [DATA_W-1:0] acc_out;
  logic              zero_flag_out;
  logic [PC_W-1:0]   pc_out;
  logic              flush_out;
  // Tallies and expected counter
  int                fail_count;
  int                n_tests;
  logic [PC_W-1:0]   exp_pc;

  core_instruction_subset_exec i_dut (
    .clk_sys_in            (clk_sys_in),
    .resetn_in             (resetn_in),
    .insn_in               (insn_in),
    .file_data_in          (file_data_in),
    .high_counter_latch_in (high_counter_latch_in),
    .file_wr_out           (file_wr_out),
    .acc_out               (acc_out),
    .zero_flag_out         (zero_flag_out),
    .pc_out                (pc_out),
    .flush_out             (flush_out)
  );

  // Free-running 100 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Four-state compare, counts every call
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One instruction cycle; valid stays high for back-to-back issue
  task automatic issue(input logic [INSN_W-1:0] word, input logic [DATA_W-1:0] fdata);
    insn_in      = '{valid: 1'b1, word: word};
    file_data_in = fdata;
    @(posedge clk_sys_in);
    #1;
    exp_pc = exp_pc + ONE_PC;
  endtask

  // Drop valid and let cycles pass; state must hold
  task automatic idle(input int n);
    insn_in.valid = 1'b0;
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // Reset held five cycles, all outputs cleared
  task automatic do_reset();
    resetn_in = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    #1;
    check({acc_out, pc_out}, 16'h0);
    check({zero_flag_out, flush_out, file_wr_out.wr}, 16'h0);
    resetn_in = 1'b1;
    exp_pc    = PC_RESET;
  endtask

  // OR with immediate, zero flag both ways, hold while idle
  task automatic t_or_imm();
    issue({OP_OR_IMM, 8'h00}, 8'h5a);
    check({acc_out, 7'h0, zero_flag_out}, 16'h0001);
    issue({OP_OR_IMM, 8'ha5}, 8'h00);
    issue({OP_OR_IMM, 8'h18}, 8'h00);
    idle(2);
    check({acc_out, 7'h0, zero_flag_out}, 16'hbd00);
    check(pc_out, exp_pc);
  endtask

  // Plain increment to both destinations, write strobe is a pulse
  task automatic t_inc();
    issue({OP_INC, 1'b0, 7'h12}, 8'hff);
    check({acc_out, 7'h0, zero_flag_out}, 16'h0001);
    check(file_wr_out.wr, 1'b0);
    issue({OP_INC, 1'b1, 7'h7f}, 8'h41);
    check(file_wr_out, {1'b1, 7'h7f, 8'h42});
    check({acc_out, 7'h0, zero_flag_out}, 16'h0000);
    idle(1);
    check(file_wr_out.wr, 1'b0);
  endtask

  // OR with register to both destinations
  task automatic t_or_reg();
    issue({OP_OR_REG, 1'b0, 7'h01}, 8'h00);
    check({acc_out, 7'h0, zero_flag_out}, 16'h0001);
    issue({OP_OR_IMM, 8'ha5}, 8'h00);
    issue({OP_OR_REG, 1'b1, 7'h03}, 8'h5a);
    check(file_wr_out, {1'b1, 7'h03, 8'hff});
    check({acc_out, 7'h0, zero_flag_out}, 16'ha500);
    issue({OP_OR_REG, 1'b0, 7'h03}, 8'h40);
    check(acc_out, 8'he5);
    idle(1);
  endtask

  // Decrement-skip: routing, skip on zero, flags untouched
  task automatic t_dec_skip();
    issue({OP_INC, 1'b0, 7'h00}, 8'hff);
    issue({OP_DEC_SKIP, 1'b0, 7'h05}, 8'h03);
    check({acc_out, 6'h0, zero_flag_out, flush_out}, 16'h0202);
    issue({OP_OR_IMM, 8'h00}, 8'h00);
    issue({OP_DEC_SKIP, 1'b1, 7'h05}, 8'h01);
    check(file_wr_out, {1'b1, 7'h05, 8'h00});
    check({zero_flag_out, flush_out}, 2'b01);
    // Skipped slot: a write that must not happen
    issue({OP_INC, 1'b1, 7'h06}, 8'h10);
    check({file_wr_out.wr, flush_out, acc_out}, {2'b00, 8'h02});
    check(pc_out, exp_pc);
    issue({OP_DEC_SKIP, 1'b0, 7'h05}, 8'h00);
    check({acc_out, flush_out}, {8'hff, 1'b0});
    idle(1);
  endtask

  // Increment-skip: routing, skip on wrap to zero, flags untouched
  task automatic t_inc_skip();
    issue({OP_INC_SKIP, 1'b0, 7'h09}, 8'hff);
    check({acc_out, 6'h0, zero_flag_out, flush_out}, 16'h0001);
    issue({OP_OR_IMM, 8'h81}, 8'h00);
    check({acc_out, flush_out}, 9'h000);
    issue({OP_INC, 1'b0, 7'h00}, 8'hff);
    issue({OP_INC_SKIP, 1'b1, 7'h09}, 8'h7f);
    check(file_wr_out, {1'b1, 7'h09, 8'h80});
    check({zero_flag_out, flush_out}, 2'b10);
    idle(1);
  endtask

  // Branch: low bits from immediate, top bits from latch, two cycles
  task automatic t_branch();
    high_counter_latch_in = 8'h18;
    issue({OP_BRANCH, 11'h7ff}, 8'h00);
    check({flush_out, pc_out}, {1'b1, 13'h1fff});
    issue({OP_OR_IMM, 8'h3c}, 8'h00);
    check({flush_out, pc_out, acc_out}, {1'b0, 13'h0000, 8'h00});
    high_counter_latch_in = 8'he7;
    issue({OP_BRANCH, 11'h2aa}, 8'h00);
    check(pc_out, 13'h02aa);
    // A branch in the skipped slot is discarded
    issue({OP_BRANCH, 11'h001}, 8'h00);
    check({flush_out, pc_out}, {1'b0, 13'h02ab});
    idle(1);
  endtask

  // Hang guard, far beyond the expected run length
  initial
  begin
    #20000;
    fail_count++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    fail_count            = 0;
    n_tests               = 0;
    exp_pc                = PC_RESET;
    resetn_in             = 1'b0;
    insn_in               = '0;
    file_data_in          = 8'h00;
    high_counter_latch_in = 8'h00;
    do_reset();
    t_or_imm();
    t_inc();
    t_or_reg();
    t_dec_skip();
    t_inc_skip();
    t_branch();
    do_reset();
    t_or_imm();
    report_and_stop();
  end
endmodule
